/* logic/fpt_top.sv */
`timescale 1ns/1ns
`include "fpt_params.svh"


module fpt_top
    import fpt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // fan
    input wire logic fan_tach_in,
    output logic fan_pwm_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    fpt_top_st_t s_r;
    fpt_top_st_t s_nxt;

    logic addr_phase;
    logic addr_ok;
    logic [7:0] a_idx;
    logic [7:0] speed_count;
    logic speed_valid;
    logic speed_sat;
    logic [7:0] status;
    logic [11:0] step_div;

    // ----------------------------------------
    // register file and bus slave
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.start_wr = 1'b0;
        a_idx = haddr[`FPT_ADDR_IDX_MSB:`FPT_ADDR_IDX_LSB];
        // upper bits and byte lanes must be clean, else unmapped
        addr_ok = (haddr[31:`FPT_ADDR_IDX_MSB+1] == '0) && (haddr[1:0] == 2'b00);
        addr_phase = hsel && hready && htrans[1];

        // data phase of a write: commit
        if (s_r.wr_pend) begin
            unique case (s_r.wr_idx)
                `FPT_IDX_DRIVE: s_nxt.drive = hwdata[7:0];
                `FPT_IDX_CLOCK: s_nxt.clock = hwdata[7:0] & `FPT_CTL_MASK;
                `FPT_IDX_START: begin
                    s_nxt.start = hwdata[7:0];
                    s_nxt.start_wr = 1'b1;
                end
                default: s_nxt.start_wr = 1'b0;
            endcase
        end

        s_nxt.wr_pend = addr_phase && hwrite && addr_ok;
        s_nxt.wr_idx = a_idx;

        // read data from post-write values so a read right after a write sees it
        if (addr_phase && !hwrite && addr_ok) begin
            unique case (a_idx)
                `FPT_IDX_DRIVE: s_nxt.rdata = {24'h000000, s_nxt.drive};
                `FPT_IDX_CLOCK: s_nxt.rdata = {24'h000000, s_nxt.clock};
                `FPT_IDX_SPEED: s_nxt.rdata = {24'h000000, speed_count};
                `FPT_IDX_STATUS: s_nxt.rdata = {24'h000000, status};
                `FPT_IDX_START: s_nxt.rdata = {24'h000000, s_nxt.start};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end else if (addr_phase) begin
            s_nxt.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r.wr_pend <= 1'b0;
            s_r.wr_idx <= 8'h00;
            s_r.drive <= `FPT_RST_DRIVE;
            s_r.clock <= `FPT_RST_CLOCK;
            s_r.start <= `FPT_RST_START;
            s_r.start_wr <= 1'b0;
            s_r.rdata <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;

    // ----------------------------------------
    // status view
    // ----------------------------------------
    always_comb begin
        status = 8'h00;
        status[`FPT_STS_VALID] = speed_valid;
        status[`FPT_STS_LEVEL] = fan_pwm_out;
        status[`FPT_STS_SAT] = speed_sat;
    end

    // ----------------------------------------
    // fan drive
    // ----------------------------------------
    assign step_div = fpt_step_div(s_r.drive[`FPT_DRV_CLKSEL],
                                   s_r.clock[`FPT_CTL_SRC],
                                   s_r.clock[`FPT_CTL_DBL]);

    fpt_pwm u_pwm (
        .core_clk(core_clk),
        .resetn(resetn),
        .force_high(s_r.drive[`FPT_DRV_FORCE]),
        .duty(s_r.drive[`FPT_DRV_DUTY_MSB:`FPT_DRV_DUTY_LSB]),
        .step_div(step_div),
        .fan_out(fan_pwm_out)
    );

    // ----------------------------------------
    // tachometer
    // ----------------------------------------
    fpt_tach u_tach (
        .core_clk(core_clk),
        .resetn(resetn),
        .div_code(s_r.clock[`FPT_CTL_DIV_MSB:`FPT_CTL_DIV_LSB]),
        .start_value(s_r.start),
        .restart(s_r.start_wr),
        .tach_in(fan_tach_in),
        .result(speed_count),
        .valid(speed_valid),
        .saturated(speed_sat)
    );

endmodule : fpt_top

/* logic/fpt_params.svh */
`ifndef FPT_PARAMS_SVH
`define FPT_PARAMS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define FPT_IDX_DRIVE 8'h56
`define FPT_IDX_CLOCK 8'h58
`define FPT_IDX_SPEED 8'h59
`define FPT_IDX_STATUS 8'h5A
`define FPT_IDX_START 8'h5B
`define FPT_ADDR_IDX_MSB 9
`define FPT_ADDR_IDX_LSB 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define FPT_RST_DRIVE 8'h00
`define FPT_RST_CLOCK 8'h10
`define FPT_RST_START 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FPT_DRV_FORCE 0
`define FPT_DRV_DUTY_LSB 1
`define FPT_DRV_DUTY_MSB 6
`define FPT_DRV_CLKSEL 7
`define FPT_CTL_SRC 0
`define FPT_CTL_DBL 2
`define FPT_CTL_DIV_LSB 4
`define FPT_CTL_DIV_MSB 5
`define FPT_CTL_MASK 8'h35
`define FPT_STS_VALID 0
`define FPT_STS_LEVEL 1
`define FPT_STS_SAT 2

// ----------------------------------------
// timing counts in core_clk cycles; valid threshold in fan pulses
// ----------------------------------------
`define FPT_STEP_SRC0_SEL0 12'd256
`define FPT_STEP_SRC1_SEL0 12'd512
`define FPT_STEP_SRC0_SEL1 12'd1024
`define FPT_STEP_SRC1_SEL1 12'd2048
`define FPT_TACH_BASE 8'd16
`define FPT_VALID_PULSES 2'd2

`endif

/* logic/fpt_pkg.sv */
`include "fpt_params.svh"

package fpt_pkg;

    typedef struct packed {
        logic [11:0] div_cnt;
        logic [5:0] step;
        logic out;
    } fpt_pwm_st_t;

    typedef struct packed {
        logic prev;
        logic [7:0] pre_cnt;
        logic [2:0] sub_cnt;
        logic [7:0] count;
        logic [7:0] result;
        logic [1:0] pulses;
        logic sat;
    } fpt_tach_st_t;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [7:0] drive;
        logic [7:0] clock;
        logic [7:0] start;
        logic start_wr;
        logic [31:0] rdata;
    } fpt_top_st_t;

    // core_clk cycles per pwm step; doubling halves it
    function automatic logic [11:0] fpt_step_div(input logic sel, input logic src,
                                                 input logic dbl);
        logic [11:0] d;
        d = sel ? (src ? `FPT_STEP_SRC1_SEL1 : `FPT_STEP_SRC0_SEL1)
                : (src ? `FPT_STEP_SRC1_SEL0 : `FPT_STEP_SRC0_SEL0);
        return dbl ? (d >> 1) : d;
    endfunction : fpt_step_div

    function automatic logic [2:0] fpt_tach_div_last(input logic [1:0] code);
        return 3'((4'h1 << code) - 4'h1);
    endfunction : fpt_tach_div_last

endpackage : fpt_pkg

/* logic/fpt_pwm.sv */
`timescale 1ns/1ns
`include "fpt_params.svh"

module fpt_pwm
    import fpt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // settings
    input wire logic force_high,
    input wire logic [5:0] duty,
    input wire logic [11:0] step_div,
    // fan drive
    output logic fan_out
);

    fpt_pwm_st_t s_r;
    fpt_pwm_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.div_cnt >= step_div - 12'h001) begin
            s_nxt.div_cnt = 12'h000;
            s_nxt.step = s_r.step + 6'h01;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 12'h001;
        end
        // high for the first duty steps of each 64-step frame
        s_nxt.out = force_high | (s_nxt.step < duty);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fan_out = s_r.out;

endmodule : fpt_pwm

/* logic/fpt_tach.sv */
`timescale 1ns/1ns
`include "fpt_params.svh"

module fpt_tach
    import fpt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // settings
    input wire logic [1:0] div_code,
    input wire logic [7:0] start_value,
    input wire logic restart,
    // fan pulse input
    input wire logic tach_in,
    // results
    output logic [7:0] result,
    output logic valid,
    output logic saturated
);

    fpt_tach_st_t s_r;
    fpt_tach_st_t s_nxt;
    logic base_tick;
    logic tick;
    logic edge_seen;

    always_comb begin
        s_nxt = s_r;
        base_tick = (s_r.pre_cnt == `FPT_TACH_BASE - 8'd1);
        tick = base_tick && (s_r.sub_cnt == fpt_tach_div_last(div_code));
        edge_seen = tach_in && !s_r.prev;
        s_nxt.prev = tach_in;
        s_nxt.pre_cnt = base_tick ? 8'd0 : s_r.pre_cnt + 8'd1;
        if (base_tick) begin
            s_nxt.sub_cnt = tick ? 3'd0 : s_r.sub_cnt + 3'd1;
        end
        if (tick) begin
            if (s_r.count == 8'hFF) begin
                s_nxt.sat = 1'b1;
            end else begin
                s_nxt.count = s_r.count + 8'd1;
            end
        end
        if (edge_seen) begin
            // a tick on the edge cycle still belongs to the closing period
            s_nxt.result = s_nxt.count;
            s_nxt.count = start_value;
            s_nxt.sat = 1'b0;
            if (s_r.pulses != `FPT_VALID_PULSES) begin
                s_nxt.pulses = s_r.pulses + 2'd1;
            end
        end
        // a preload write wins over a coincident fan edge
        if (restart) begin
            s_nxt.count = start_value;
            s_nxt.pre_cnt = 8'd0;
            s_nxt.sub_cnt = 3'd0;
            s_nxt.sat = 1'b0;
            s_nxt.pulses = 2'd0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign result = s_r.result;
    assign valid = (s_r.pulses == `FPT_VALID_PULSES);
    assign saturated = s_r.sat;

endmodule : fpt_tach

/* dv/fpt_assertions.sv */
`timescale 1ns/1ns
`include "fpt_params.svh"
module fpt_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // fan
    input wire logic fan_tach_in,
    input wire logic fan_pwm_out
);
    // ----------
    // shadows
    // ----------
    logic wr_r, rd_r, ok_r;
    logic [7:0] idx_r, drv_r, clk_r, pre_r, spd_r;
    logic [3:0] qt_r, qw_r;
    wire take = hsel && hready && htrans[1];
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {wr_r, rd_r, ok_r, idx_r, drv_r, pre_r, spd_r, qt_r, qw_r} <= '0;
            clk_r <= `FPT_RST_CLOCK;
        end else begin
            wr_r <= take && hwrite;
            rd_r <= take && !hwrite;
            idx_r <= haddr[9:2];
            // quiet counters keep edge checks off settling glitches
            qt_r <= fan_tach_in ? 4'h0 : qt_r + {3'h0, qt_r != 4'hF};
            qw_r <= (wr_r && idx_r <= 8'h58) ? 4'h0 : qw_r + {3'h0, qw_r != 4'hF};
            if (wr_r && idx_r == `FPT_IDX_DRIVE) drv_r <= hwdata[7:0];
            if (wr_r && idx_r == `FPT_IDX_CLOCK) clk_r <= hwdata[7:0] & `FPT_CTL_MASK;
            if (wr_r && idx_r == `FPT_IDX_START) pre_r <= hwdata[7:0];
            if (fan_tach_in) ok_r <= 1'b0;
            else if (rd_r && idx_r == `FPT_IDX_SPEED && qt_r == 4'hF) begin
                ok_r <= 1'b1;
                spd_r <= hrdata[7:0];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_force; drv_r[0] && $past(drv_r[0]) |-> fan_pwm_out; endproperty
    a_force: assert property (p_force) else $error("fan not forced");
    property p_zero; drv_r[6:0] == 7'h0 && $past(drv_r[6:0]) == 7'h0 |-> !fan_pwm_out; endproperty
    a_zero: assert property (p_zero) else $error("fan high at zero duty");
    property p_hi; $rose(fan_pwm_out) && qw_r == 4'hF |-> fan_pwm_out [*8]; endproperty
    a_hi: assert property (p_hi) else $error("short high step");
    property p_lo; $fell(fan_pwm_out) && qw_r == 4'hF |-> !fan_pwm_out [*8]; endproperty
    a_lo: assert property (p_lo) else $error("short low step");
    property p_drv; rd_r && idx_r == `FPT_IDX_DRIVE |-> hrdata == {24'h0, drv_r}; endproperty
    a_drv: assert property (p_drv) else $error("drive readback");
    property p_clk; rd_r && idx_r == `FPT_IDX_CLOCK |-> hrdata == {24'h0, clk_r}; endproperty
    a_clk: assert property (p_clk) else $error("clock readback");
    property p_pre; rd_r && idx_r == `FPT_IDX_START |-> hrdata == {24'h0, pre_r}; endproperty
    a_pre: assert property (p_pre) else $error("start readback");
    property p_spd; rd_r && idx_r == `FPT_IDX_SPEED && ok_r |-> hrdata[7:0] == spd_r; endproperty
    a_spd: assert property (p_spd) else $error("speed moved without pulse");
endmodule : fpt_checker
bind fpt_top fpt_checker u_chk (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .fan_tach_in, .fan_pwm_out);

/* dv/fpt_fan_model.sv */
`timescale 1ns/1ns
module fpt_fan_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // pulse spacing in cycles, zero for a stopped rotor
    input wire logic [15:0] period,
    // tachometer
    output logic tach_out
);
    logic [15:0] cnt_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 16'h0;
            tach_out <= 1'b0;
        end else begin
            cnt_r <= (cnt_r + 16'h1 >= period) ? 16'h0 : cnt_r + 16'h1;
            // four-cycle pulse, line idles low when stopped
            tach_out <= period != 16'h0 && cnt_r < 16'h4;
        end
    end
endmodule : fpt_fan_model

/* dv/tb.sv */
`timescale 1ns/1ns
`include "fpt_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
    logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = '0;
    logic [15:0] period = 16'h0;
    wire hreadyout, hresp, fan_tach_in, fan_pwm_out;
    int fail_count = 0, checks_done = 0, hi, lo;
    logic [7:0] dv[4] = '{8'h40, 8'h7E, 8'h82, 8'h02};
    logic [7:0] ck[4] = '{8'h04, 8'h04, 8'h04, 8'h05};
    int eh[4] = '{4096, 8064, 512, 256};
    int el[4] = '{4096, 128, 0, 0};
    logic [1:0] tc[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [7:0] tp[5] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'hF0};
    logic [7:0] te[5] = '{8'h20, 8'h10, 8'h0F, 8'h04, 8'hFF};
    always #4 core_clk = ~core_clk;
    fpt_top dut (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .fan_tach_in, .fan_pwm_out);
    fpt_fan_model fan (.core_clk, .resetn, .period, .tach_out(fan_tach_in));
    // ----------
    // bus tasks
    // ----------
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, i, 2'h0};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        `CHK(q, e)
        `CHK({hresp, hreadyout}, 2'b01)
    endtask : rd
    task automatic pulses(input int n);
        repeat (n) begin
            do @(posedge core_clk); while (fan_tach_in !== 1'b0);
            do @(posedge core_clk); while (fan_tach_in !== 1'b1);
        end
        // long enough for the checker to see a quiet tach line at the read
        repeat (24) @(posedge core_clk);
    endtask : pulses
    task automatic meas(input logic wl);
        // settle first so a mid-frame rise from the new duty is skipped
        repeat (3) @(posedge core_clk);
        do @(posedge core_clk); while (fan_pwm_out !== 1'b0);
        do @(posedge core_clk); while (fan_pwm_out !== 1'b1);
        hi = 0;
        lo = 0;
        while (fan_pwm_out === 1'b1) begin
            @(posedge core_clk);
            hi++;
        end
        while (wl && fan_pwm_out === 1'b0) begin
            @(posedge core_clk);
            lo++;
        end
    endtask : meas
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // ----------
    // tests
    // ----------
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        period <= 16'h0200;
        @(posedge core_clk);
        rd(`FPT_IDX_DRIVE, 32'h0);
        rd(`FPT_IDX_CLOCK, 32'h10);
        rd(`FPT_IDX_SPEED, 32'h0);
        rd(`FPT_IDX_START, 32'h0);
        rd(8'h57, 32'h0);
        bus(1'b1, `FPT_IDX_CLOCK, 32'hFF);
        rd(`FPT_IDX_CLOCK, 32'h35);
        bus(1'b1, `FPT_IDX_DRIVE, 32'h01);
        repeat (3) @(posedge core_clk);
        `CHK(fan_pwm_out, 1'b1)
        bus(1'b1, `FPT_IDX_DRIVE, 32'h00);
        repeat (3) @(posedge core_clk);
        `CHK(fan_pwm_out, 1'b0)
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, `FPT_IDX_CLOCK, {24'h0, ck[k]});
            bus(1'b1, `FPT_IDX_DRIVE, {24'h0, dv[k]});
            meas(el[k] != 0);
            `CHK(hi, eh[k])
            if (el[k] != 0) `CHK(lo, el[k])
        end
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, `FPT_IDX_CLOCK, {26'h0, tc[k], 4'h4});
            bus(1'b1, `FPT_IDX_START, {24'h0, tp[k]});
            pulses(3);
            rd(`FPT_IDX_SPEED, {24'h0, te[k]});
            rd(`FPT_IDX_SPEED, {24'h0, te[k]});
        end
        bus(1'b1, `FPT_IDX_START, 32'h0);
        pulses(3);
        repeat (232) @(posedge core_clk);
        bus(1'b1, `FPT_IDX_START, 32'h0);
        pulses(1);
        bus(1'b0, `FPT_IDX_SPEED, 32'h0);
        `CHK(q[7:0] inside {[8'd14:8'd16]}, 1'b1)
        end_sim();
    end
    initial begin
        #800000;
        fail_count++;
        end_sim();
    end
endmodule : tb
